// ==== include/dma_pkg.sv ====
// Register map, field layout and state codes of the four-channel DMA controller
package dma_pkg;
	localparam int NUM_CH = 4;
	localparam int ADDR_W = 24;
	localparam int CNT_W = 25;
	localparam int NUM_INT_SRC = 14;
	// Per-channel register indices, channel number in paddr[6:5]
	localparam logic [2:0] SRC_IDX = 3'h0;
	localparam logic [2:0] DST_IDX = 3'h1;
	localparam logic [2:0] CNT_IDX = 3'h2;
	localparam logic [2:0] CTL_IDX = 3'h3;
	localparam logic [2:0] TBL_IDX = 3'h4;
	localparam logic [2:0] REM_IDX = 3'h5;
	localparam int CH_SEL_LSB = 5;
	localparam int REG_SEL_LSB = 2;
	localparam logic [7:0] GCTL_OFF = 8'h80;
	localparam logic [7:0] STAT_OFF = 8'h84;
	// Channel control fields
	localparam int EN_BIT = 0;
	localparam int ONE_BIT = 1;
	localparam int WIDE_BIT = 2;
	localparam int BURST_BIT = 3;
	localparam int CONT_LSB = 4;
	localparam int SDIR_LSB = 6;
	localparam int DDIR_LSB = 8;
	localparam int SEL_LSB = 10;
	localparam int LVL_BIT = 14;
	localparam int IOW_BIT = 15;
	localparam int BLK_LSB = 16;
	localparam int ROT_BIT = 0;
	localparam int DONE_LSB = 8;
	localparam logic [3:0] SEL_EXT = 4'he;
	localparam logic [1:0] CONT_SINGLE = 2'h0;
	localparam logic [1:0] CONT_REPEAT = 2'h1;
	localparam logic [1:0] CONT_ARRAY = 2'h2;
	localparam logic [1:0] CONT_LINK = 2'h3;
	localparam logic [1:0] DIR_INC = 2'h1;
	localparam logic [1:0] DIR_DEC = 2'h2;
	localparam logic [1:0] OWN_REFRESH = 2'h0;
	localparam logic [1:0] OWN_HOLD = 2'h1;
	localparam logic [1:0] OWN_DMA = 2'h2;
	localparam logic [1:0] OWN_CPU = 2'h3;
	localparam logic [23:0] CTL_RST = 24'h000000;
	localparam logic [2:0] ARRAY_LAST_HW = 3'h5;
	localparam logic [2:0] LINK_LAST_HW = 3'h7;
	typedef enum logic [4:0] {
		IDLE_ST = 5'b00001,
		READ_ST = 5'b00010,
		WRITE_ST = 5'b00100,
		ONE_ST = 5'b01000,
		FETCH_ST = 5'b10000
	} eng_type;
endpackage : dma_pkg

// ==== design/dma_controller.sv ====
// Four-channel DMA engine with APB registers, bus ownership arbiter and chain fetch
//
// Design decisions made here: the address map and the APB interface to the registers.
module dma_controller (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic refresh_req,
	input wire logic hold_req,
	input wire logic cpu_bus_busy,
	input wire logic [dma_pkg::NUM_INT_SRC-1:0] int_req,
	input wire logic [dma_pkg::NUM_CH-1:0] external_transfer_request_pin_n,
	input wire logic terminal_count_pin_n,
	output logic bus_owner_code_low,
	output logic bus_owner_code_high,
	output logic [dma_pkg::ADDR_W-1:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic mem_rd,
	output logic mem_wr,
	output logic mem_wide,
	output logic io_strobe,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);
	import dma_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		eng_type st;
		logic [1:0] own;
		logic [1:0] ch;
		logic [1:0] last;
		logic lock;
		logic rot;
		logic [3:0][23:0] psrc;
		logic [3:0][23:0] pdst;
		logic [3:0][24:0] pcnt;
		logic [3:0][23:0] ctl;
		logic [3:0][23:0] ptbl;
		logic [3:0][23:0] wsrc;
		logic [3:0][23:0] wdst;
		logic [3:0][24:0] wcnt;
		logic [3:0][23:0] wptr;
		logic [3:0][7:0] wblk;
		logic [3:0] nfetch;
		logic [3:0] pend;
		logic [3:0] done;
		logic [2:0] fi;
		logic [127:0] fbuf;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic wide;
		logic io;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] ext_s1;
		logic [3:0] ext_s2;
		logic [3:0] ext_s3;
		logic tc_s1;
		logic tc_s2;
		logic tc_s3;
		logic tc_hit;
	} state_type;

	state_type q;
	state_type n;

	// ==========================================================
	// Helpers
	function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] dir,
			input logic wide);
		logic [23:0] amt;
		amt = wide ? 24'h000002 : 24'h000001;
		case (dir)
			DIR_INC: step_addr = a + amt;
			DIR_DEC: step_addr = a - amt;
			default: step_addr = a;
		endcase
	endfunction : step_addr

	// Returns {found, channel}; lower index wins, or rotation starts after last served
	function automatic logic [2:0] pick_ch(input logic [3:0] cand, input logic rot,
			input logic [1:0] last);
		logic [1:0] idx;
		logic [2:0] r;
		r = 3'h0;
		for (int k = 3; k >= 0; k--) begin
			idx = rot ? 2'(last + 2'(k) + 2'h1) : 2'(k);
			if (cand[idx]) begin
				r = {1'b1, idx};
			end
		end
		pick_ch = r;
	endfunction : pick_ch

	function automatic state_type start_unit(input state_type s, input logic [1:0] c);
		state_type r;
		r = s;
		r.wide = s.ctl[c][WIDE_BIT];
		if (s.ctl[c][ONE_BIT]) begin
			// Memory side addressed, I/O side strobed in the same cycle
			r.st = ONE_ST;
			r.io = 1'b1;
			r.wr = s.ctl[c][IOW_BIT];
			r.rd = ~s.ctl[c][IOW_BIT];
			r.addr = s.ctl[c][IOW_BIT] ? s.wdst[c] : s.wsrc[c];
		end else begin
			r.st = READ_ST;
			r.rd = 1'b1;
			r.addr = s.wsrc[c];
		end
		start_unit = r;
	endfunction : start_unit

	function automatic state_type start_fetch(input state_type s, input logic [1:0] c);
		state_type r;
		r = s;
		r.st = FETCH_ST;
		r.fi = 3'h0;
		r.rd = 1'b1;
		r.wide = 1'b1;
		r.addr = s.wptr[c];
		start_fetch = r;
	endfunction : start_fetch

	// ==========================================================
	// Next state
	logic [3:0] cand;
	logic [3:0] lvl_mode;
	logic [3:0] ext_low;
	logic [3:0] sel;
	logic [2:0] p;
	logic [1:0] c;
	logic [1:0] mode;
	logic [24:0] amt;
	logic [127:0] fb;
	logic [2:0] lasthw;
	logic tc_fall;
	logic fin;
	logic bend;
	logic trig;

	always_comb begin
		n = q;
		cand = 4'h0;
		lvl_mode = 4'h0;
		ext_low = 4'h0;
		sel = 4'h0;
		p = 3'h0;
		c = q.ch;
		mode = q.ctl[q.ch][CONT_LSB +: 2];
		amt = 25'h0;
		fb = q.fbuf;
		lasthw = 3'h0;
		fin = 1'b0;
		bend = 1'b0;
		trig = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		// Pin synchronisers
		n.ext_s1 = external_transfer_request_pin_n;
		n.ext_s2 = q.ext_s1;
		n.ext_s3 = q.ext_s2;
		n.tc_s1 = terminal_count_pin_n;
		n.tc_s2 = q.tc_s1;
		n.tc_s3 = q.tc_s2;
		tc_fall = q.tc_s3 & ~q.tc_s2;
		// Hold a terminal count edge until the running burst reaches its unit boundary
		n.tc_hit = (q.tc_hit | tc_fall) & q.lock;

		// ======================================================
		// APB slave, one wait cycle per access
		if (psel && penable && !q.pready) begin
			n.pready = 1'b1;
			n.prdata = 32'h0;
			if (!paddr[7]) begin
				c = paddr[CH_SEL_LSB +: 2];
				case (paddr[REG_SEL_LSB +: 3])
					SRC_IDX: begin
						n.prdata = {8'h0, q.psrc[c]};
						if (pwrite) n.psrc[c] = pwdata[23:0];
					end
					DST_IDX: begin
						n.prdata = {8'h0, q.pdst[c]};
						if (pwrite) n.pdst[c] = pwdata[23:0];
					end
					CNT_IDX: begin
						n.prdata = {7'h0, q.pcnt[c]};
						if (pwrite) n.pcnt[c] = pwdata[24:0];
					end
					CTL_IDX: begin
						n.prdata = {8'h0, q.ctl[c]};
						if (pwrite) begin
							n.ctl[c] = pwdata[23:0];
							if (pwdata[EN_BIT] && !q.ctl[c][EN_BIT]) begin
								n.done[c] = 1'b0;
								n.pend[c] = 1'b0;
								n.wptr[c] = q.ptbl[c];
								n.wblk[c] = pwdata[BLK_LSB +: 8];
								n.nfetch[c] = pwdata[CONT_LSB + 1];
								n.wsrc[c] = q.psrc[c];
								n.wdst[c] = q.pdst[c];
								n.wcnt[c] = q.pcnt[c];
							end
							if (!pwdata[EN_BIT]) begin
								n.nfetch[c] = 1'b0;
								n.pend[c] = 1'b0;
								if (q.ch == c) n.lock = 1'b0;
							end
						end
					end
					TBL_IDX: begin
						n.prdata = {8'h0, q.ptbl[c]};
						if (pwrite) n.ptbl[c] = pwdata[23:0];
					end
					REM_IDX: n.prdata = {7'h0, q.wcnt[c]};
					default: n.pslverr = 1'b1;
				endcase
			end else if (paddr == GCTL_OFF) begin
				n.prdata = {31'h0, q.rot};
				if (pwrite) n.rot = pwdata[ROT_BIT];
			end else if (paddr == STAT_OFF) begin
				n.prdata = {20'h0, q.done, 3'h0, q.lock, q.ch, q.own};
				if (pwrite) n.done = q.done & ~pwdata[DONE_LSB +: 4];
			end else begin
				n.pslverr = 1'b1;
			end
		end

		// ======================================================
		// Request sources and candidates
		for (int k = 0; k < NUM_CH; k++) begin
			sel = q.ctl[k][SEL_LSB +: 4];
			ext_low[k] = ~q.ext_s2[k];
			lvl_mode[k] = (sel == SEL_EXT) && q.ctl[k][LVL_BIT];
			cand[k] = q.ctl[k][EN_BIT] &&
				(q.nfetch[k] || q.pend[k] || (lvl_mode[k] && ext_low[k]));
		end
		if (q.lock) begin
			// Locked channel alone may run; level mode pauses while its pin is high
			cand = 4'h0;
			cand[q.ch] = q.ctl[q.ch][EN_BIT] &&
				(q.nfetch[q.ch] || !lvl_mode[q.ch] || ext_low[q.ch]);
		end

		// ======================================================
		// Engine
		case (q.st)
			IDLE_ST: begin
				p = pick_ch(cand, q.rot, q.last);
				if (refresh_req) begin
					n.own = OWN_REFRESH;
				end else if (hold_req) begin
					n.own = OWN_HOLD;
				end else if (p[2] && !cpu_bus_busy) begin
					n.own = OWN_DMA;
					n.ch = p[1:0];
					n.last = p[1:0];
					if (q.nfetch[p[1:0]]) begin
						n = start_fetch(n, p[1:0]);
					end else begin
						n.pend[p[1:0]] = 1'b0;
						n.lock = q.ctl[p[1:0]][BURST_BIT];
						n = start_unit(n, p[1:0]);
					end
				end else begin
					n.own = OWN_CPU;
				end
			end
			READ_ST: begin
				if (mem_ack) begin
					n.rd = 1'b0;
					n.wr = 1'b1;
					n.st = WRITE_ST;
					n.addr = q.wdst[q.ch];
					n.wdata = mem_rdata;
				end
			end
			WRITE_ST, ONE_ST: begin
				if (mem_ack) begin
					n.rd = 1'b0;
					n.wr = 1'b0;
					n.io = 1'b0;
					fin = 1'b1;
				end
			end
			FETCH_ST: begin
				if (mem_ack) begin
					// Parameter set: source, destination, count, then link pointer in link mode only
					fb[q.fi * 16 +: 16] = mem_rdata;
					n.fbuf = fb;
					n.fi = q.fi + 3'h1;
					n.wptr[q.ch] = q.wptr[q.ch] + 24'h000002;
					lasthw = (mode == CONT_LINK) ? LINK_LAST_HW : ARRAY_LAST_HW;
					if (q.fi == lasthw) begin
						n.rd = 1'b0;
						n.wsrc[q.ch] = fb[23:0];
						n.wdst[q.ch] = fb[55:32];
						n.wcnt[q.ch] = fb[88:64];
						if (mode == CONT_LINK) begin
							n.wptr[q.ch] = fb[119:96];
						end
						n.nfetch[q.ch] = 1'b0;
						n.st = IDLE_ST;
					end else begin
						n.addr = q.wptr[q.ch] + 24'h000002;
					end
				end
			end
			default: n.st = IDLE_ST;
		endcase

		// ======================================================
		// End of one unit
		if (fin) begin
			c = q.ch;
			amt = q.ctl[c][WIDE_BIT] ? 25'h2 : 25'h1;
			n.wsrc[c] = step_addr(q.wsrc[c], q.ctl[c][SDIR_LSB +: 2], q.ctl[c][WIDE_BIT]);
			n.wdst[c] = step_addr(q.wdst[c], q.ctl[c][DDIR_LSB +: 2], q.ctl[c][WIDE_BIT]);
			n.wcnt[c] = (q.wcnt[c] > amt) ? q.wcnt[c] - amt : 25'h0;
			bend = (q.wcnt[c] <= amt);
			n.st = IDLE_ST;
			if (bend) begin
				case (mode)
					CONT_SINGLE: begin
						n.ctl[c][EN_BIT] = 1'b0;
						n.done[c] = 1'b1;
					end
					CONT_REPEAT: begin
						n.wsrc[c] = q.psrc[c];
						n.wdst[c] = q.pdst[c];
						n.wcnt[c] = q.pcnt[c];
					end
					CONT_ARRAY: begin
						n.wblk[c] = q.wblk[c] - 8'h1;
						if (q.wblk[c] <= 8'h1) begin
							n.ctl[c][EN_BIT] = 1'b0;
							n.done[c] = 1'b1;
						end else begin
							n.nfetch[c] = 1'b1;
						end
					end
					default: begin
						if (q.wptr[c] == 24'h0) begin
							n.ctl[c][EN_BIT] = 1'b0;
							n.done[c] = 1'b1;
						end else begin
							n.nfetch[c] = 1'b1;
						end
					end
				endcase
				if (mode != CONT_ARRAY && mode != CONT_LINK) n.lock = 1'b0;
			end
			if (q.ctl[c][BURST_BIT] && (tc_fall || q.tc_hit)) begin
				n.ctl[c][EN_BIT] = 1'b0;
				n.nfetch[c] = 1'b0;
				n.done[c] = 1'b1;
			end
			n.tc_hit = 1'b0;
			if (!n.ctl[c][EN_BIT]) n.lock = 1'b0;
			// Burst keeps the bus unless refresh, hold or a high level request intervene
			if (n.lock && !refresh_req && !hold_req &&
					(!lvl_mode[c] || ext_low[c])) begin
				if (n.nfetch[c]) begin
					n = start_fetch(n, c);
				end else begin
					n = start_unit(n, c);
				end
			end
		end

		// ======================================================
		// Latch requests last so a new request beats a clear
		for (int k = 0; k < NUM_CH; k++) begin
			sel = q.ctl[k][SEL_LSB +: 4];
			if (sel < 4'(NUM_INT_SRC)) begin
				trig = int_req[sel];
			end else if (sel == SEL_EXT && !q.ctl[k][LVL_BIT]) begin
				trig = q.ext_s3[k] & ~q.ext_s2[k];
			end else begin
				trig = 1'b0;
			end
			if (trig && q.ctl[k][EN_BIT]) begin
				n.pend[k] = 1'b1;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= IDLE_ST;
			q.own <= OWN_CPU;
			q.ext_s1 <= 4'hf;
			q.ext_s2 <= 4'hf;
			q.ext_s3 <= 4'hf;
			q.tc_s1 <= 1'b1;
			q.tc_s2 <= 1'b1;
			q.tc_s3 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign bus_owner_code_low = q.own[0];
	assign bus_owner_code_high = q.own[1];
	assign mem_addr = q.addr;
	assign mem_wdata = q.wdata;
	assign mem_rd = q.rd;
	assign mem_wr = q.wr;
	assign mem_wide = q.wide;
	assign io_strobe = q.io;
endmodule : dma_controller

// ==== verification/dma_controller_properties.sv ====
// Concurrent checks on bus ownership and memory access of the DMA controller
module dma_controller_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic refresh_req,
	input wire logic hold_req,
	input wire logic cpu_bus_busy,
	input wire logic bus_owner_code_low,
	input wire logic bus_owner_code_high,
	input wire logic [dma_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_wide,
	input wire logic io_strobe,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);
	import dma_pkg::*;
	logic [1:0] own;
	assign own = {bus_owner_code_high, bus_owner_code_low};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// =====
	// Ownership
	property p_mem_granted;
		(mem_rd || mem_wr) |-> own == OWN_DMA;
	endproperty
	a_mem_granted: assert property (p_mem_granted)
		else $error("memory access without ownership");
	property p_entry;
		(own == OWN_DMA && $past(own) != OWN_DMA) |->
			!$past(refresh_req) && !$past(hold_req) && !$past(cpu_bus_busy);
	endproperty
	a_entry: assert property (p_entry)
		else $error("bus taken over a higher owner");
	property p_refresh_keeps;
		own == OWN_REFRESH && refresh_req |=> own == OWN_REFRESH;
	endproperty
	a_refresh_keeps: assert property (p_refresh_keeps)
		else $error("refresh lost the bus");
	property p_refresh_preempt;
		own == OWN_DMA && refresh_req |-> ##[0:80] own == OWN_REFRESH;
	endproperty
	a_refresh_preempt: assert property (p_refresh_preempt)
		else $error("refresh not served");
	property p_hold_preempt;
		own == OWN_DMA && hold_req && !refresh_req |-> ##[0:80] own == OWN_HOLD;
	endproperty
	a_hold_preempt: assert property (p_hold_preempt)
		else $error("hold not served");
	// =====
	// Memory accesses
	property p_steady;
		(mem_rd || mem_wr) && !mem_ack |=> $stable({mem_rd, mem_wr, mem_addr, mem_wide})
			&& (!mem_wr || $stable(mem_wdata));
	endproperty
	a_steady: assert property (p_steady)
		else $error("access changed before ack");
	property p_read_then_write;
		$rose(mem_wr) && !io_strobe |->
			$past(mem_rd && mem_ack) && mem_wdata[7:0] == $past(mem_rdata[7:0]);
	endproperty
	a_read_then_write: assert property (p_read_then_write)
		else $error("write without preceding read");
	property p_one_bus;
		$rose(mem_rd || mem_wr) && io_strobe |-> !(mem_rd && mem_wr);
	endproperty
	a_one_bus: assert property (p_one_bus)
		else $error("one-bus unit split");
endmodule : dma_controller_checker

bind dma_controller dma_controller_checker u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.refresh_req(refresh_req),
	.hold_req(hold_req),
	.cpu_bus_busy(cpu_bus_busy),
	.bus_owner_code_low(bus_owner_code_low),
	.bus_owner_code_high(bus_owner_code_high),
	.mem_addr(mem_addr),
	.mem_wdata(mem_wdata),
	.mem_rd(mem_rd),
	.mem_wr(mem_wr),
	.mem_wide(mem_wide),
	.io_strobe(io_strobe),
	.mem_rdata(mem_rdata),
	.mem_ack(mem_ack)
);

// ==== verification/mem_model.sv ====
// Behavioural memory and I/O on the far side of the system bus
module mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [dma_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [1:0] slow,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	import dma_pkg::*;
	logic [1:0] wait_q;
	int wr_cnt;
	logic [ADDR_W-1:0] last_addr;
	logic [15:0] last_data;
	// One ack per access, also for a one-bus unit; data line toggles in every cycle without an ack, wait cycles included
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_q <= 2'h0;
			mem_rdata <= 16'h0000;
			wr_cnt <= 0;
		end else if ((mem_rd || mem_wr) && !mem_ack && wait_q == slow) begin
			mem_ack <= 1'b1;
			wait_q <= 2'h0;
			mem_rdata <= mem_addr[15:0] ^ 16'ha5c3;
			if (mem_wr) begin
				wr_cnt <= wr_cnt + 1;
				last_addr <= mem_addr;
				last_data <= mem_wdata;
			end
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if ((mem_rd || mem_wr) && !mem_ack)
				wait_q <= wait_q + 2'h1;
		end
	end
endmodule : mem_model

// ==== verification/four_channel_dma_controller_test.sv ====
// Self-checking bench for the four-channel DMA controller
module four_channel_dma_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dma_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, refresh_req, hold_req;
	logic cpu_bus_busy, tc_n, own_lo, own_hi, mem_rd, mem_wr, mem_wide, io_strobe, mem_ack, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [13:0] int_req;
	logic [3:0] ext_n;
	logic [23:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [1:0] slow, own;
	int n_mismatch, n_checks, c;
	assign own = {own_hi, own_lo};
	dma_controller u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .refresh_req(refresh_req), .hold_req(hold_req),
		.cpu_bus_busy(cpu_bus_busy), .int_req(int_req),
		.external_transfer_request_pin_n(ext_n), .terminal_count_pin_n(tc_n),
		.bus_owner_code_low(own_lo), .bus_owner_code_high(own_hi), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wide(mem_wide),
		.io_strobe(io_strobe), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .slow(slow),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	// =====
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		// Request stands until pready is seen high at a rising edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cfg(input logic [7:0] b, input logic [31:0] s, d, n, ctl);
		apb(b, 1'b1, s);
		apb(b + 8'h04, 1'b1, d);
		apb(b + 8'h08, 1'b1, n);
		apb(b + 8'h0c, 1'b1, ctl);
		c = u_mem.wr_cnt;
	endtask : cfg
	task automatic pulse(input int b);
		@(posedge pclk);
		int_req <= 14'h1 << b;
		@(posedge pclk);
		int_req <= 14'h0;
	endtask : pulse
	task automatic wait_wr(input int t);
		int n;
		for (n = 0; n < 300 && u_mem.wr_cnt < t; n++) @(negedge pclk);
		check("writes", u_mem.wr_cnt, t);
	endtask : wait_wr
	task automatic wait_own(input logic [1:0] v);
		int n;
		for (n = 0; n < 200 && own !== v; n++) @(negedge pclk);
		check("owner", own, v);
	endtask : wait_own
	task automatic wait_done(input int ch);
		int n;
		for (n = 0; n < 100 && rdat[DONE_LSB+ch] !== 1'b1; n++) apb(STAT_OFF, 1'b0, 0);
		check("done", rdat[DONE_LSB+ch], 1'b1);
	endtask : wait_done
	// =====
	// Scenarios
	task automatic t_reset();
		check("owner", own, 2'h3);
		check("rd", mem_rd, 1'b0);
		apb(8'h0c, 1'b0, 0);
		check("ctl", rdat, 0);
		apb(8'h18, 1'b0, 0);
		check("unmapped", rerr, 1'b1);
	endtask : t_reset
	task automatic t_burst();
		slow <= 2'h2;
		rdat = 0;
		cfg(8'h20, 32'h000100, 32'h800010, 4, 32'h0d49);
		pulse(3);
		wait_wr(c + 1);
		@(posedge pclk);
		refresh_req <= 1'b1;
		wait_own(2'h0);
		check("rd", mem_rd | mem_wr, 1'b0);
		@(posedge pclk);
		refresh_req <= 1'b0;
		wait_done(1);
		check("count", u_mem.wr_cnt, c + 4);
		check("addr", u_mem.last_addr, 24'h800013);
		check("data", u_mem.last_data[7:0], 8'hc0);
		pulse(3);
		repeat (40) @(posedge pclk);
		check("again", u_mem.wr_cnt, c + 4);
	endtask : t_burst
	task automatic t_steal();
		slow <= 2'h0;
		cfg(8'h40, 32'h000200, 32'h000400, 8, 32'h3605);
		cpu_bus_busy <= 1'b1;
		pulse(13);
		repeat (8) @(posedge pclk);
		check("busy", u_mem.wr_cnt, c);
		cpu_bus_busy <= 1'b0;
		wait_wr(c + 1);
		repeat (20) @(posedge pclk);
		check("one", u_mem.wr_cnt, c + 1);
		check("data", u_mem.last_data, 16'ha7c3);
		check("owner", own, 2'h3);
		pulse(13);
		wait_wr(c + 2);
		check("addr", u_mem.last_addr, 24'h0003fe);
	endtask : t_steal
	task automatic t_onebus();
		cfg(8'h60, 32'h0, 32'h000600, 2, 32'hb903);
		@(posedge pclk);
		ext_n <= 4'h7;
		repeat (4) @(posedge pclk);
		ext_n <= 4'hf;
		wait_wr(c + 1);
		check("addr", u_mem.last_addr, 24'h000600);
	endtask : t_onebus
	task automatic t_term();
		slow <= 2'h1;
		rdat = 0;
		cfg(8'h00, 32'h1000, 32'h2000, 64, 32'h0149);
		pulse(0);
		wait_wr(c + 2);
		@(posedge pclk);
		hold_req <= 1'b1;
		wait_own(2'h1);
		@(posedge pclk);
		hold_req <= 1'b0;
		wait_wr(c + 3);
		@(posedge pclk);
		tc_n <= 1'b0;
		wait_done(0);
		check("stop", u_mem.wr_cnt - c < 12, 1'b1);
		tc_n <= 1'b1;
	endtask : t_term
	task automatic t_chain();
		// Table halfwords read back as src 78007a, dst 7c007e, count 2
		apb(8'h30, 1'b1, 32'h00a5b9);
		cfg(8'h20, 0, 0, 0, 32'h1156d);
		repeat (30) @(posedge pclk);
		check("fetch", u_mem.wr_cnt, c);
		pulse(5);
		wait_wr(c + 1);
		check("addr", u_mem.last_addr, 24'h7c007e);
		check("data", u_mem.last_data, 16'ha5b9);
		wait_done(1);
		apb(8'h34, 1'b0, 0);
		check("rem", rdat, 0);
	endtask : t_chain
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// =====
	// Run
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		results();
	end
	initial begin
		{psel, penable, pwrite, refresh_req, hold_req, cpu_bus_busy} = 6'h00;
		{paddr, pwdata, int_req, slow} = '0;
		ext_n = 4'hf;
		tc_n = 1'b1;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_burst();
		t_steal();
		t_onebus();
		t_term();
		t_chain();
		results();
	end
endmodule : four_channel_dma_controller_test
